//--- rtl/spct_pkg.sv
package spct_pkg;

  // channel 0 is the shear, channels 1 to 5 are the punch presses
  localparam int CH_NUM    = 6;
  localparam int SHEAR_CH  = 0;

  // field widths: milliseconds for times, feet per minute for speeds
  localparam int DWELL_W   = 15;
  localparam int BOOST_W   = 14;
  localparam int LEAD_W    = 10;
  localparam int VEL_W     = 10;
  localparam int TTT_W     = 16;
  localparam int TICK_W    = 18;

  // configuration switch positions within cfg_sw (switch n at bit n-1)
  localparam int SW1_BIT   = 0;
  localparam int SW2_BIT   = 1;
  localparam int SW4_BIT   = 3;
  localparam int SW5_BIT   = 4;
  localparam int SW6_BIT   = 5;
  localparam int CFG_W     = 6;

  // timing: one timer step is one millisecond
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_NS       = 1000000;
  localparam int TICK_CYC      = STEP_NS / CLK_PERIOD_NS;

  // reset values
  localparam logic [DWELL_W-1:0] DWELL_ZERO = 15'h0000;
  localparam logic [BOOST_W-1:0] BOOST_ZERO = 14'h0000;
  localparam logic [LEAD_W-1:0]  LEAD_ZERO  = 10'h000;
  localparam logic [VEL_W-1:0]   VEL_ZERO   = 10'h000;
  localparam logic [TICK_W-1:0]  TICK_ZERO  = 18'h00000;

  typedef enum logic [1:0] {
    DN_IDLE,
    DN_DOWN,
    DN_UP
  } spct_dn_type;

  typedef enum logic {
    BS_IDLE,
    BS_ON
  } spct_bs_type;

endpackage

//--- rtl/spct_sync.sv
`timescale 1ns/1ps
module spct_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q feeds sync_q and nothing else
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

//--- rtl/spct_tick.sv
`timescale 1ns/1ps
module spct_tick
  import spct_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYC
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  output logic      tick
);

  localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_LEN - 1);

  logic [TICK_W-1:0] cnt_q;
  logic [TICK_W-1:0] cnt_d;
  logic              tick_q;
  logic              tick_d;

  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? TICK_ZERO : cnt_q + 18'h00001;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q  <= TICK_ZERO;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

//--- rtl/spct_top.sv
`timescale 1ns/1ps
// How it works
// - down output held for programmed down dwell
// - completion input may end down dwell early
// - up output held for programmed up dwell
// - timed up only with switch 2 on
// - boost output held for boost dwell, automatic
// - shear boost needs switch 1 on, 2 off
// - shear down fires early by reaction lead
// - boost fires early by its own lead
// - boost suppressed below enable velocity
// - zero enable velocity means no speed limit
// - missing completion raises error, leaves run mode
// - each press has its own down dwell
// - press up needs switch 2 and press switch
// - press boost needs switches 1 on, 2 off
// - press down early needs switches 1 and 4
// - press boost early by its own lead
// - press boost gated by own enable velocity
module spct_top
  import spct_pkg::*;
#(
  parameter int unsigned TICK_LEN = spct_pkg::TICK_CYC
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  sys_rst,
  input  wire logic [spct_pkg::CFG_W-1:0]            cfg_sw,
  input  wire logic [spct_pkg::CH_NUM-1:0]           manual_start,
  input  wire logic [spct_pkg::CH_NUM-1:0]           auto_cycle,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::TTT_W-1:0]
                                                     time_to_target_ms,
  input  wire logic [spct_pkg::VEL_W-1:0]            line_speed_fpm,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::DWELL_W-1:0]
                                                     dwell_down_ms,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::DWELL_W-1:0]
                                                     dwell_up_ms,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::BOOST_W-1:0]
                                                     dwell_boost_ms,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::LEAD_W-1:0]
                                                     lead_down_ms,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::LEAD_W-1:0]
                                                     lead_boost_ms,
  input  wire logic [spct_pkg::CH_NUM-1:0][spct_pkg::VEL_W-1:0]
                                                     boost_vel_fpm,
  input  wire logic [spct_pkg::CH_NUM-1:0]           cmp_in_use,
  input  wire logic [spct_pkg::CH_NUM-1:0]           expect_cmp,
  input  wire logic [spct_pkg::CH_NUM-1:0]           cmp_sw,
  input  wire logic [spct_pkg::CH_NUM-1:0]           err_clr,
  output logic      [spct_pkg::CH_NUM-1:0]           down_out,
  output logic      [spct_pkg::CH_NUM-1:0]           up_out,
  output logic      [spct_pkg::CH_NUM-1:0]           boost_out,
  output logic      [spct_pkg::CH_NUM-1:0]           cmp_err,
  output logic                                       run_exit
);

  import spct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and millisecond step

  logic [CFG_W-1:0]  sw_s;
  logic [CH_NUM-1:0] cmp_s;
  logic              tick;

  spct_sync #(
    .WIDTH (CFG_W + CH_NUM)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({cfg_sw, cmp_sw}),
    .sync_out ({sw_s, cmp_s})
  );

  // timers step on a shared tick, so a dwell may run short by up to one
  // step; finer per-channel phase was traded for one shared prescaler
  spct_tick #(
    .TICK_LEN (TICK_LEN)
  ) u_tick (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode

  logic press_cfg;
  logic up_cfg;
  logic boost_cfg;
  logic sh_lead_cfg;
  logic pr_lead_cfg;

  always_comb begin
    press_cfg   = sw_s[SW4_BIT] | sw_s[SW5_BIT] | sw_s[SW6_BIT];
    up_cfg      = sw_s[SW2_BIT];
    boost_cfg   = sw_s[SW1_BIT] & ~sw_s[SW2_BIT];
    sh_lead_cfg = sw_s[SW1_BIT];
    pr_lead_cfg = sw_s[SW1_BIT] & sw_s[SW4_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel press cycle

  logic [CH_NUM-1:0] err_set;
  logic [CH_NUM-1:0] down_q;
  logic [CH_NUM-1:0] up_q;
  logic [CH_NUM-1:0] boost_q;

  genvar gi;
  generate
    for (gi = 0; gi < CH_NUM; gi++) begin : g_ch
      spct_dn_type        st_q;
      spct_dn_type        st_d;
      spct_bs_type        bs_q;
      spct_bs_type        bs_d;
      logic [DWELL_W-1:0] cnt_q;
      logic [DWELL_W-1:0] cnt_d;
      logic [BOOST_W-1:0] bcnt_q;
      logic [BOOST_W-1:0] bcnt_d;
      logic               fired_q;
      logic               fired_d;
      logic               bfired_q;
      logic               bfired_d;
      logic               ch_en;
      logic               up_en;
      logic               boost_en;
      logic [LEAD_W-1:0]  lead_dn;
      logic               auto_fire;
      logic               boost_win;
      logic               vel_ok;
      logic               cmp_end;
      logic               go_up;
      logic               err_d;

      // enables and early-fire windows
      always_comb begin
        if (gi == SHEAR_CH) begin
          ch_en    = 1'b1;
          lead_dn  = sh_lead_cfg ? lead_down_ms[gi] : LEAD_ZERO;
        end else begin
          ch_en    = press_cfg;
          lead_dn  = pr_lead_cfg ? lead_down_ms[gi] : LEAD_ZERO;
        end
        up_en     = ch_en & up_cfg;
        boost_en  = ch_en & boost_cfg;
        auto_fire = auto_cycle[gi] & ~fired_q &
                    (time_to_target_ms[gi] <= TTT_W'(lead_dn));
        boost_win = boost_en & auto_cycle[gi] & ~bfired_q &
                    (time_to_target_ms[gi] <=
                     TTT_W'(lead_boost_ms[gi]));
        vel_ok    = (boost_vel_fpm[gi] == VEL_ZERO) |
                    (line_speed_fpm >= boost_vel_fpm[gi]);
        cmp_end   = cmp_s[gi] & (cmp_in_use[gi] | expect_cmp[gi]);
      end

      // down and up sequence
      always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        fired_d    = auto_cycle[gi] ? fired_q : 1'b0;
        err_d      = 1'b0;
        go_up      = 1'b0;
        case (st_q)
          DN_IDLE: begin
            if (ch_en && (manual_start[gi] || auto_fire)) begin
              st_d  = DN_DOWN;
              cnt_d = dwell_down_ms[gi];
              if (auto_fire) begin
                fired_d = 1'b1;
              end
            end
          end
          DN_DOWN: begin
            if (cmp_end) begin
              go_up = 1'b1;
            end else if (tick && cnt_q <= 15'h0001) begin
              go_up = 1'b1;
              err_d = expect_cmp[gi];
            end else if (tick) begin
              cnt_d = cnt_q - 15'h0001;
            end
          end
          DN_UP: begin
            if (tick && cnt_q <= 15'h0001) begin
              st_d = DN_IDLE;
            end else if (tick) begin
              cnt_d = cnt_q - 15'h0001;
            end
          end
          default: begin
            st_d = DN_IDLE;
          end
        endcase
        // up only follows a finished down, so the two never overlap
        if (go_up) begin
          if (up_en && dwell_up_ms[gi] != DWELL_ZERO) begin
            st_d  = DN_UP;
            cnt_d = dwell_up_ms[gi];
          end else begin
            st_d = DN_IDLE;
          end
        end
      end

      // boost runs beside the down sequence; the speed is judged once per
      // cycle, so a slow line at the window's start skips the boost whole
      always_comb begin
        bs_d     = bs_q;
        bcnt_d   = bcnt_q;
        bfired_d = auto_cycle[gi] ? bfired_q : 1'b0;
        case (bs_q)
          BS_IDLE: begin
            if (boost_win) begin
              bfired_d = 1'b1;
              if (vel_ok && dwell_boost_ms[gi] != BOOST_ZERO) begin
                bs_d   = BS_ON;
                bcnt_d = dwell_boost_ms[gi];
              end
            end
          end
          BS_ON: begin
            if (tick && bcnt_q <= 14'h0001) begin
              bs_d = BS_IDLE;
            end else if (tick) begin
              bcnt_d = bcnt_q - 14'h0001;
            end
          end
          default: begin
            bs_d = BS_IDLE;
          end
        endcase
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          st_q        <= DN_IDLE;
          bs_q        <= BS_IDLE;
          cnt_q       <= DWELL_ZERO;
          bcnt_q      <= BOOST_ZERO;
          fired_q     <= 1'b0;
          bfired_q    <= 1'b0;
          down_q[gi]  <= 1'b0;
          up_q[gi]    <= 1'b0;
          boost_q[gi] <= 1'b0;
        end else begin
          st_q        <= st_d;
          bs_q        <= bs_d;
          cnt_q       <= cnt_d;
          bcnt_q      <= bcnt_d;
          fired_q     <= fired_d;
          bfired_q    <= bfired_d;
          down_q[gi]  <= (st_d == DN_DOWN);
          up_q[gi]    <= (st_d == DN_UP);
          boost_q[gi] <= (bs_d == BS_ON);
        end
      end

      assign err_set[gi] = err_d;

      //////////////////////////////////////////////////////////////////////
      // checks

      a_down_up_excl: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !(down_q[gi] && up_q[gi]))
        else $error("down and up outputs asserted together");

      a_up_after_down: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(up_q[gi]) |-> $past(down_q[gi]) && $past(up_cfg))
        else $error("up output started without a preceding down");

      a_boost_cfg_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(boost_q[gi]) |-> $past(boost_cfg))
        else $error("boost started outside flying cutoff setting");

      a_boost_vel_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(boost_q[gi]) |->
          ($past(boost_vel_fpm[gi]) == VEL_ZERO) ||
          ($past(line_speed_fpm) >= $past(boost_vel_fpm[gi])))
        else $error("boost started below enable velocity");

      a_boost_lead_win: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(boost_q[gi]) |-> $past(time_to_target_ms[gi]) <=
          TTT_W'($past(lead_boost_ms[gi])))
        else $error("boost started outside its lead window");

      a_manual_start: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (st_q == DN_IDLE) && ch_en && manual_start[gi] |=> down_q[gi])
        else $error("manual start did not raise down output");

      a_cmp_ends_down: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        down_q[gi] && cmp_end |=> !down_q[gi])
        else $error("completion input did not end down dwell");

      a_err_on_expire: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        down_q[gi] && tick && cnt_q <= 15'h0001 && !cmp_end &&
          expect_cmp[gi] |=> cmp_err[gi] && run_exit)
        else $error("missed completion did not flag an error");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // completion errors: a new error wins over a clear in the same cycle

  logic [CH_NUM-1:0] err_q;
  logic [CH_NUM-1:0] err_d;
  logic              exit_q;
  logic              exit_d;

  always_comb begin
    err_d  = (err_q & ~err_clr) | err_set;
    exit_d = |err_set;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      err_q  <= '0;
      exit_q <= 1'b0;
    end else begin
      err_q  <= err_d;
      exit_q <= exit_d;
    end
  end

  assign down_out  = down_q;
  assign up_out    = up_q;
  assign boost_out = boost_q;
  assign cmp_err   = err_q;
  assign run_exit  = exit_q;

endmodule

//--- verif/spct_valve_model.sv
`timescale 1ns/1ps
module spct_valve_model (
  input  wire logic [spct_pkg::CH_NUM-1:0] down_out,
  input  wire logic                        sys_clk,
  input  wire logic [spct_pkg::CH_NUM-1:0] sw_fitted,
  input  wire logic [7:0]                  close_lag,
  output logic      [spct_pkg::CH_NUM-1:0] cmp_sw
);
  import spct_pkg::*;
  int stroke [CH_NUM] = '{default: 0};
  // a missing or open switch reads low through its pull-down; a fitted
  // one closes once the die has travelled close_lag cycles
  initial cmp_sw = '0;
  always @(posedge sys_clk) begin
    for (int c = 0; c < CH_NUM; c++) begin
      stroke[c] <= (down_out[c] === 1'b1) ? stroke[c] + 1 : 0;
      cmp_sw[c] <= sw_fitted[c] && (down_out[c] === 1'b1)
                   && (stroke[c] >= close_lag);
    end
  end
endmodule

//--- verif/tb_shear_press_cycle_timing.sv
`timescale 1ns/1ps
module tb_shear_press_cycle_timing;
  import spct_pkg::*;
  localparam int T = 10;
  typedef struct {int k; int c; int lo; int hi;} spct_exp_type;
  logic                         sys_clk, sys_rst, run_exit;
  logic [CFG_W-1:0]             cfg_sw;
  logic [CH_NUM-1:0]            manual_start, auto_cycle, cmp_in_use;
  logic [CH_NUM-1:0]            expect_cmp, cmp_sw, err_clr, sw_fitted;
  logic [CH_NUM-1:0]            down_out, up_out, boost_out, cmp_err;
  logic [CH_NUM-1:0][TTT_W-1:0] time_to_target_ms;
  logic [VEL_W-1:0]             line_speed_fpm;
  logic [CH_NUM-1:0][DWELL_W-1:0] dwell_down_ms, dwell_up_ms;
  logic [CH_NUM-1:0][BOOST_W-1:0] dwell_boost_ms;
  logic [CH_NUM-1:0][LEAD_W-1:0]  lead_down_ms, lead_boost_ms;
  logic [CH_NUM-1:0][VEL_W-1:0]   boost_vel_fpm;
  logic [7:0]                   close_lag;
  logic [CH_NUM-1:0]            o;
  spct_exp_type                 exp_q[$];
  int n_errors = 0, total_checks = 0, n_exit = 0, cycles = 0;
  int cnt [3][CH_NUM] = '{default: 0};

  spct_top #(.TICK_LEN(T)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_sw(cfg_sw),
    .manual_start(manual_start), .auto_cycle(auto_cycle),
    .time_to_target_ms(time_to_target_ms),
    .line_speed_fpm(line_speed_fpm), .dwell_down_ms(dwell_down_ms),
    .dwell_up_ms(dwell_up_ms), .dwell_boost_ms(dwell_boost_ms),
    .lead_down_ms(lead_down_ms), .lead_boost_ms(lead_boost_ms),
    .boost_vel_fpm(boost_vel_fpm), .cmp_in_use(cmp_in_use),
    .expect_cmp(expect_cmp), .cmp_sw(cmp_sw), .err_clr(err_clr),
    .down_out(down_out), .up_out(up_out), .boost_out(boost_out),
    .cmp_err(cmp_err), .run_exit(run_exit));
  spct_valve_model u_valve (
    .down_out(down_out), .sys_clk(sys_clk), .sw_fitted(sw_fitted),
    .close_lag(close_lag), .cmp_sw(cmp_sw));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(string w, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", w, e, g);
    end
  endtask

  // each finished pulse is matched against the oldest note, in order
  task automatic take(int k, int c, int w);
    spct_exp_type e;
    total_checks++;
    e = spct_exp_type'{-1, -1, 0, 0};
    if (exp_q.size() != 0) e = exp_q.pop_front();
    if (e.k != k || e.c != c || w < e.lo || w > e.hi) begin
      n_errors++;
      $display("mismatch pulse expected k%0d c%0d %0d..%0d seen k%0d c%0d %0d",
               e.k, e.c, e.lo, e.hi, k, c, w);
    end
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    // ceiling far above the planned run, only a hang reaches it
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
    if (run_exit === 1'b1) n_exit++;
    for (int k = 0; k < 3; k++) begin
      o = (k == 0) ? down_out : (k == 1) ? up_out : boost_out;
      for (int c = 0; c < CH_NUM; c++) begin
        if (o[c] === 1'b1) begin
          cnt[k][c]++;
        end else if (cnt[k][c] != 0) begin
          take(k, c, cnt[k][c]);
          cnt[k][c] = 0;
        end
      end
    end
  end

  // a dwell of n ms lands within one prescaler period
  task automatic push(int k, int c, int n);
    exp_q.push_back('{k, c, (n - 1) * T + 1, n * T});
  endtask

  task automatic fire(int c);
    @(negedge sys_clk);
    manual_start[c] = 1'b1;
    @(negedge sys_clk);
    manual_start[c] = 1'b0;
  endtask

  task automatic wait_idle(int c);
    repeat (3) @(negedge sys_clk);
    while ((down_out[c] | up_out[c] | boost_out[c]) !== 1'b0)
      @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic run_manual(int c, bit en, bit up_en);
    int dn, up;
    dn = 1 + $urandom % 4;
    up = $urandom % 3;
    dwell_down_ms[c] = 15'(dn);
    dwell_up_ms[c] = 15'(up);
    if (en) push(0, c, dn);
    if (en && up_en && up != 0) push(1, c, up);
    fire(c);
    wait_idle(c);
  endtask

  task automatic run_cmp(int c, bit fit, bit chk);
    int e0;
    e0 = n_exit;
    sw_fitted[c] = fit;
    cmp_in_use[c] = fit;
    expect_cmp[c] = chk;
    dwell_down_ms[c] = 15'd4;
    dwell_up_ms[c] = 15'd0;
    if (fit) exp_q.push_back('{0, c, 4, 9});
    else push(0, c, 4);
    fire(c);
    wait_idle(c);
    check("cmp_err", {31'b0, chk & ~fit}, {31'b0, cmp_err[c]});
    check("run_exit", 32'(chk & ~fit), 32'(n_exit - e0));
    err_clr[c] = 1'b1;
    @(negedge sys_clk);
    err_clr[c] = 1'b0;
    @(negedge sys_clk);
    check("cmp_err clr", 32'h0, {31'b0, cmp_err[c]});
    {sw_fitted[c], cmp_in_use[c], expect_cmp[c]} = 3'b000;
  endtask

  task automatic run_auto(int c, int spd, int vel, bit bst);
    int dn;
    dn = 1 + $urandom % 3;
    dwell_down_ms[c] = 15'(dn);
    dwell_boost_ms[c] = 14'h0001;
    lead_down_ms[c] = 10'h002;
    lead_boost_ms[c] = 10'h004;
    line_speed_fpm = 10'(spd);
    boost_vel_fpm[c] = 10'(vel);
    time_to_target_ms[c] = 16'h0064;
    auto_cycle[c] = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("far", 32'h0, {30'b0, boost_out[c], down_out[c]});
    if (bst) push(2, c, 1);
    time_to_target_ms[c] = 16'h0004;
    repeat (3 * T) @(negedge sys_clk);
    check("down lead", 32'h0, {31'b0, down_out[c]});
    push(0, c, dn);
    time_to_target_ms[c] = 16'h0002;
    wait_idle(c);
    repeat (2 * T) @(negedge sys_clk);
    auto_cycle[c] = 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    int v;
    void'($urandom(32'hd39a9a41));
    {manual_start, auto_cycle, cmp_in_use, expect_cmp} = '0;
    {err_clr, sw_fitted, cfg_sw, line_speed_fpm} = '0;
    {dwell_down_ms, dwell_up_ms, dwell_boost_ms} = '0;
    {lead_down_ms, lead_boost_ms, boost_vel_fpm} = '0;
    time_to_target_ms = '0;
    close_lag = 8'h03;
    sys_rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    cfg_sw = 6'h02;
    repeat (4) @(negedge sys_clk);
    run_manual(0, 1, 1);
    run_manual(1, 0, 1);
    cfg_sw = 6'h00;
    repeat (4) @(negedge sys_clk);
    run_manual(0, 1, 0);
    cfg_sw = 6'h0a;
    // switches pass two flip-flops; let them settle before a press cycle
    repeat (4) @(negedge sys_clk);
    for (int c = 1; c < CH_NUM; c++) run_manual(c, 1, 1);
    run_cmp(0, 1, 0);
    run_cmp(0, 0, 1);
    run_cmp(3, 0, 1);
    cfg_sw = 6'h09;
    repeat (4) @(negedge sys_clk);
    run_manual(0, 1, 0);
    for (int c = 0; c < CH_NUM; c++) begin
      v = 1 + $urandom % 500;
      run_auto(c, v + $urandom % 500, v, 1);
      run_auto(c, v - 1, v, 0);
      run_auto(c, 0, 0, 1);
    end
    check("left", 32'h0, 32'(exp_q.size()));
    print_verdict();
  end
endmodule
